// [verilog/flag_bank_params.svh]
// Constants of the interrupt flag bank: offsets, masks and bit positions
// Contract
// [R1] Second bank high byte: uart2, pins, timers, compares
// [R2] Second bank low: captures, adc2, pin1, notify, i2c1
// [R3] Unimplemented bits ignore writes, read zero
// [R4] Flag reads one once its source requested
// [R5] Flags read/write, zero after reset
// [R6] Third bank high: timer6, dma4, compares 8-5, capture6
// [R7] Third bank low byte: captures, dma3, can1, spi2
// [R8] Fourth bank bits 13,12,11,8: dma5, codec port, can2
// [R9] Fourth bank low: can2 rx, pins, timers, i2c2
// [R10] First bank bits 2-0: compare1, capture1, pin0
// [R11] Enable bit gates each flag onto request
// [R12] Event pulse sets; software zero clears; event wins
// [R13] Handler clears its flag before returning
`ifndef FLAG_BANK_PARAMS_SVH
`define FLAG_BANK_PARAMS_SVH

// Register indices on the plain register port
`define REG_FLAGS_FIRST    4'h0
`define REG_FLAGS_SECOND   4'h1
`define REG_FLAGS_THIRD    4'h2
`define REG_FLAGS_FOURTH   4'h3
`define REG_ENABLE_FIRST   4'h4
`define REG_ENABLE_SECOND  4'h5
`define REG_ENABLE_THIRD   4'h6
`define REG_ENABLE_FOURTH  4'h7
`define REG_COUNT          8
`define FLAG_BANKS         4

// Implemented-bit masks, shared by flags and enables
`define MASK_FIRST         16'h0007
`define MASK_SECOND        16'hfffb
`define MASK_THIRD         16'hdfff
`define MASK_FOURTH        16'h39ff
`define WORD_RESET         16'h0000

// First bank
`define OCMP1_FLAG_BIT          2
`define ICAP1_FLAG_BIT          1
`define EXTPIN0_FLAG_BIT        0
// Second bank
`define UART2_TX_FLAG_BIT       15
`define UART2_RX_FLAG_BIT       14
`define EXTPIN2_FLAG_BIT        13
`define TIMER5_FLAG_BIT         12
`define TIMER4_FLAG_BIT         11
`define OCMP4_FLAG_BIT          10
`define OCMP3_FLAG_BIT          9
`define DMA_CH2_DONE_FLAG_BIT   8
`define ICAP8_FLAG_BIT          7
`define ICAP7_FLAG_BIT          6
`define ADC2_DONE_FLAG_BIT      5
`define EXTPIN1_FLAG_BIT        4
`define CHANGE_NOTIFY_FLAG_BIT  3
`define I2C1_MASTER_FLAG_BIT    1
`define I2C1_SLAVE_FLAG_BIT     0
// Third bank
`define TIMER6_FLAG_BIT         15
`define DMA_CH4_DONE_FLAG_BIT   14
`define OCMP8_FLAG_BIT          12
`define OCMP7_FLAG_BIT          11
`define OCMP6_FLAG_BIT          10
`define OCMP5_FLAG_BIT          9
`define ICAP6_FLAG_BIT          8
`define ICAP5_FLAG_BIT          7
`define ICAP4_FLAG_BIT          6
`define ICAP3_FLAG_BIT          5
`define DMA_CH3_DONE_FLAG_BIT   4
`define CAN1_EVENT_FLAG_BIT     3
`define CAN1_RX_READY_FLAG_BIT  2
`define SPI2_EVENT_FLAG_BIT     1
`define SPI2_ERROR_FLAG_BIT     0
// Fourth bank
`define DMA_CH5_DONE_FLAG_BIT   13
`define CODEC_PORT_EVENT_BIT    12
`define CODEC_PORT_ERROR_BIT    11
`define CAN2_EVENT_FLAG_BIT     8
`define CAN2_RX_READY_FLAG_BIT  7
`define EXTPIN4_FLAG_BIT        6
`define EXTPIN3_FLAG_BIT        5
`define TIMER9_FLAG_BIT         4
`define TIMER8_FLAG_BIT         3
`define I2C2_MASTER_FLAG_BIT    2
`define I2C2_SLAVE_FLAG_BIT     1
`define TIMER7_FLAG_BIT         0

`endif

// [verilog/flag_bank_pkg.sv]
// Types and decode helpers of the interrupt flag bank
`default_nettype none
`include "flag_bank_params.svh"
package flag_bank_pkg;
  typedef logic [15:0] flag_word_t;  // One 16-bit register
  typedef logic [3:0]  reg_addr_t;   // Register index

  // Implemented bits of register idx (flag or enable alike)
  function automatic flag_word_t impl_mask(input reg_addr_t idx);
    case (idx)
      `REG_FLAGS_FIRST, `REG_ENABLE_FIRST:   impl_mask = `MASK_FIRST;
      `REG_FLAGS_SECOND, `REG_ENABLE_SECOND: impl_mask = `MASK_SECOND;
      `REG_FLAGS_THIRD, `REG_ENABLE_THIRD:   impl_mask = `MASK_THIRD;
      `REG_FLAGS_FOURTH, `REG_ENABLE_FOURTH: impl_mask = `MASK_FOURTH;
      default:                               impl_mask = `WORD_RESET;
    endcase
  endfunction
endpackage
`default_nettype wire

// [verilog/flag_cell.sv]
// One flag or enable register with write, event set and masked bits
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_params.svh"
module flag_cell
  import flag_bank_pkg::*;
#(
  parameter flag_bank_pkg::flag_word_t IMPL_MASK = 16'hffff
) (
  input  wire logic                       mclk_i,   // Core clock
  input  wire logic                       nrst_i,   // Async reset, low
  input  wire logic                       wr_i,     // Software write
  input  wire flag_bank_pkg::flag_word_t  wdata_i,  // Software data
  input  wire flag_bank_pkg::flag_word_t  set_i,    // Event pulses
  output logic [15:0]                     value_o   // Register value
);
  import flag_bank_pkg::*;

  flag_word_t word_q;  // Stored bits
  flag_word_t word_d;  // Next value

  // Event OR'd after the write so a same-cycle clear loses
  always_comb begin
    if (wr_i) begin
      word_d = wdata_i | set_i;       // see [R5] see [R12]
    end else begin
      word_d = word_q | set_i;        // see [R4] see [R12]
    end
    word_d = word_d & IMPL_MASK;      // see [R3]
  end

  // Cleared at power-on
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_q <= `WORD_RESET;          // see [R5]
    end else begin
      word_q <= word_d;
    end
  end

  assign value_o = word_q;
endmodule
`default_nettype wire

// [verilog/reg_read_mux.sv]
// Read selection over the flag and enable registers
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_params.svh"
module reg_read_mux
  import flag_bank_pkg::*;
(
  input  wire flag_bank_pkg::reg_addr_t  addr_i,            // Index
  input  wire logic [15:0]               words_i [`REG_COUNT], // All regs
  output logic [15:0]                    rdata_o            // Selected
);
  import flag_bank_pkg::*;

  // Unmapped indices answer zero; mask keeps reserved bits at zero
  always_comb begin
    if (addr_i < reg_addr_t'(`REG_COUNT)) begin
      rdata_o = words_i[addr_i[2:0]] & impl_mask(addr_i); // see [R3]
    end else begin
      rdata_o = `WORD_RESET;
    end
  end
endmodule
`default_nettype wire

// [verilog/interrupt_flag_status_bank.sv]
// Top of the interrupt flag bank: event mapping, registers, request
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_params.svh"
module interrupt_flag_status_bank
  import flag_bank_pkg::*;
(
  input  wire logic                      mclk_i,          // 250 MHz clock
  input  wire logic                      nrst_i,          // Async reset
  // Register port
  input  wire flag_bank_pkg::reg_addr_t  addr_i,          // Index
  input  wire flag_bank_pkg::flag_word_t wdata_i,         // Write data
  input  wire logic                      wr_i,            // Write strobe
  input  wire logic                      rd_i,            // Read strobe
  output flag_bank_pkg::flag_word_t      rdata_o,         // Read data
  // Event pulses, one cycle each, same clock
  input  wire logic                      ocmp1_evt_i,
  input  wire logic                      icap1_evt_i,
  input  wire logic                      extpin0_evt_i,
  input  wire logic                      uart2_tx_evt_i,
  input  wire logic                      uart2_rx_evt_i,
  input  wire logic                      extpin2_evt_i,
  input  wire logic                      timer5_evt_i,
  input  wire logic                      timer4_evt_i,
  input  wire logic                      ocmp4_evt_i,
  input  wire logic                      ocmp3_evt_i,
  input  wire logic                      dma_ch2_done_evt_i,
  input  wire logic                      icap8_evt_i,
  input  wire logic                      icap7_evt_i,
  input  wire logic                      adc2_done_evt_i,
  input  wire logic                      extpin1_evt_i,
  input  wire logic                      change_notify_evt_i,
  input  wire logic                      i2c1_master_evt_i,
  input  wire logic                      i2c1_slave_evt_i,
  input  wire logic                      timer6_evt_i,
  input  wire logic                      dma_ch4_done_evt_i,
  input  wire logic                      ocmp8_evt_i,
  input  wire logic                      ocmp7_evt_i,
  input  wire logic                      ocmp6_evt_i,
  input  wire logic                      ocmp5_evt_i,
  input  wire logic                      icap6_evt_i,
  input  wire logic                      icap5_evt_i,
  input  wire logic                      icap4_evt_i,
  input  wire logic                      icap3_evt_i,
  input  wire logic                      dma_ch3_done_evt_i,
  input  wire logic                      can1_event_evt_i,
  input  wire logic                      can1_rx_ready_evt_i,
  input  wire logic                      spi2_event_evt_i,
  input  wire logic                      spi2_error_evt_i,
  input  wire logic                      dma_ch5_done_evt_i,
  input  wire logic                      codec_port_event_evt_i,
  input  wire logic                      codec_port_error_evt_i,
  input  wire logic                      can2_event_evt_i,
  input  wire logic                      can2_rx_ready_evt_i,
  input  wire logic                      extpin4_evt_i,
  input  wire logic                      extpin3_evt_i,
  input  wire logic                      timer9_evt_i,
  input  wire logic                      timer8_evt_i,
  input  wire logic                      i2c2_master_evt_i,
  input  wire logic                      i2c2_slave_evt_i,
  input  wire logic                      timer7_evt_i,
  // Flag words toward the priority logic
  output flag_bank_pkg::flag_word_t      flags_first_o,
  output flag_bank_pkg::flag_word_t      flags_second_o,
  output flag_bank_pkg::flag_word_t      flags_third_o,
  output flag_bank_pkg::flag_word_t      flags_fourth_o,
  output logic                           irq_o            // Level request
);
  import flag_bank_pkg::*;

  flag_word_t evt_word [`FLAG_BANKS];  // Events placed at their bits
  logic [15:0] reg_word [`REG_COUNT];  // All register values
  flag_word_t rd_word;                 // Selected read value
  flag_word_t rdata_q;                 // Registered read data
  logic       irq_q;                   // Registered request
  logic       irq_d;                   // Next request

  // Place each source pulse at its documented bit
  always_comb begin
    for (int b = 0; b < `FLAG_BANKS; b++) begin
      evt_word[b] = `WORD_RESET;
    end
    // First bank
    evt_word[0][`OCMP1_FLAG_BIT]         = ocmp1_evt_i;         // see [R10]
    evt_word[0][`ICAP1_FLAG_BIT]         = icap1_evt_i;         // see [R10]
    evt_word[0][`EXTPIN0_FLAG_BIT]       = extpin0_evt_i;       // see [R10]
    // Second bank, high byte
    evt_word[1][`UART2_TX_FLAG_BIT]      = uart2_tx_evt_i;      // see [R1]
    evt_word[1][`UART2_RX_FLAG_BIT]      = uart2_rx_evt_i;      // see [R1]
    evt_word[1][`EXTPIN2_FLAG_BIT]       = extpin2_evt_i;       // see [R1]
    evt_word[1][`TIMER5_FLAG_BIT]        = timer5_evt_i;        // see [R1]
    evt_word[1][`TIMER4_FLAG_BIT]        = timer4_evt_i;        // see [R1]
    evt_word[1][`OCMP4_FLAG_BIT]         = ocmp4_evt_i;         // see [R1]
    evt_word[1][`OCMP3_FLAG_BIT]         = ocmp3_evt_i;         // see [R1]
    evt_word[1][`DMA_CH2_DONE_FLAG_BIT]  = dma_ch2_done_evt_i;  // see [R1]
    // Second bank, low byte; bit 2 stays empty
    evt_word[1][`ICAP8_FLAG_BIT]         = icap8_evt_i;         // see [R2]
    evt_word[1][`ICAP7_FLAG_BIT]         = icap7_evt_i;         // see [R2]
    evt_word[1][`ADC2_DONE_FLAG_BIT]     = adc2_done_evt_i;     // see [R2]
    evt_word[1][`EXTPIN1_FLAG_BIT]       = extpin1_evt_i;       // see [R2]
    evt_word[1][`CHANGE_NOTIFY_FLAG_BIT] = change_notify_evt_i; // see [R2]
    evt_word[1][`I2C1_MASTER_FLAG_BIT]   = i2c1_master_evt_i;   // see [R2]
    evt_word[1][`I2C1_SLAVE_FLAG_BIT]    = i2c1_slave_evt_i;    // see [R2]
    // Third bank, high byte; bit 13 stays empty
    evt_word[2][`TIMER6_FLAG_BIT]        = timer6_evt_i;        // see [R6]
    evt_word[2][`DMA_CH4_DONE_FLAG_BIT]  = dma_ch4_done_evt_i;  // see [R6]
    evt_word[2][`OCMP8_FLAG_BIT]         = ocmp8_evt_i;         // see [R6]
    evt_word[2][`OCMP7_FLAG_BIT]         = ocmp7_evt_i;         // see [R6]
    evt_word[2][`OCMP6_FLAG_BIT]         = ocmp6_evt_i;         // see [R6]
    evt_word[2][`OCMP5_FLAG_BIT]         = ocmp5_evt_i;         // see [R6]
    evt_word[2][`ICAP6_FLAG_BIT]         = icap6_evt_i;         // see [R6]
    // Third bank, low byte
    evt_word[2][`ICAP5_FLAG_BIT]         = icap5_evt_i;         // see [R7]
    evt_word[2][`ICAP4_FLAG_BIT]         = icap4_evt_i;         // see [R7]
    evt_word[2][`ICAP3_FLAG_BIT]         = icap3_evt_i;         // see [R7]
    evt_word[2][`DMA_CH3_DONE_FLAG_BIT]  = dma_ch3_done_evt_i;  // see [R7]
    evt_word[2][`CAN1_EVENT_FLAG_BIT]    = can1_event_evt_i;    // see [R7]
    evt_word[2][`CAN1_RX_READY_FLAG_BIT] = can1_rx_ready_evt_i; // see [R7]
    evt_word[2][`SPI2_EVENT_FLAG_BIT]    = spi2_event_evt_i;    // see [R7]
    evt_word[2][`SPI2_ERROR_FLAG_BIT]    = spi2_error_evt_i;    // see [R7]
    // Fourth bank, high byte; 15-14 and 10-9 stay empty
    evt_word[3][`DMA_CH5_DONE_FLAG_BIT]  = dma_ch5_done_evt_i;  // see [R8]
    evt_word[3][`CODEC_PORT_EVENT_BIT]   = codec_port_event_evt_i; // see [R8]
    evt_word[3][`CODEC_PORT_ERROR_BIT]   = codec_port_error_evt_i; // see [R8]
    evt_word[3][`CAN2_EVENT_FLAG_BIT]    = can2_event_evt_i;    // see [R8]
    // Fourth bank, low byte
    evt_word[3][`CAN2_RX_READY_FLAG_BIT] = can2_rx_ready_evt_i; // see [R9]
    evt_word[3][`EXTPIN4_FLAG_BIT]       = extpin4_evt_i;       // see [R9]
    evt_word[3][`EXTPIN3_FLAG_BIT]       = extpin3_evt_i;       // see [R9]
    evt_word[3][`TIMER9_FLAG_BIT]        = timer9_evt_i;        // see [R9]
    evt_word[3][`TIMER8_FLAG_BIT]        = timer8_evt_i;        // see [R9]
    evt_word[3][`I2C2_MASTER_FLAG_BIT]   = i2c2_master_evt_i;   // see [R9]
    evt_word[3][`I2C2_SLAVE_FLAG_BIT]    = i2c2_slave_evt_i;    // see [R9]
    evt_word[3][`TIMER7_FLAG_BIT]        = timer7_evt_i;        // see [R9]
  end

  // Flags at indices 0-3, enables at 4-7; enables take no events
  for (genvar r = 0; r < `REG_COUNT; r++) begin : g_reg
    flag_cell #(
      .IMPL_MASK (impl_mask(reg_addr_t'(r)))
    ) u_cell (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .wr_i    (wr_i && (addr_i == reg_addr_t'(r))),
      .wdata_i (wdata_i),
      .set_i   ((r < `FLAG_BANKS) ? evt_word[r % `FLAG_BANKS]
                                  : flag_word_t'(`WORD_RESET)),
      .value_o (reg_word[r])
    );
  end

  // Read selection, reserved bits zero
  reg_read_mux u_rd_mux (
    .addr_i  (addr_i),
    .words_i (reg_word),
    .rdata_o (rd_word)
  );

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= `WORD_RESET;
    end else if (rd_i) begin
      rdata_q <= rd_word;
    end else begin
      rdata_q <= `WORD_RESET;
    end
  end

  // Request while any enabled flag is set; a still-set flag retriggers
  always_comb begin
    irq_d = 1'b0;
    for (int b = 0; b < `FLAG_BANKS; b++) begin
      irq_d = irq_d
            | (|(reg_word[b] & reg_word[b + `FLAG_BANKS])); // see [R11]
    end
  end

  // Registered so the output is glitch free; adds one cycle of latency
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign rdata_o        = rdata_q;
  assign irq_o          = irq_q;
  assign flags_first_o  = reg_word[0];
  assign flags_second_o = reg_word[1];
  assign flags_third_o  = reg_word[2];
  assign flags_fourth_o = reg_word[3];
endmodule
`default_nettype wire

// [tb/event_source.sv]
// Model of the peripheral event sources feeding the flag bank
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input  wire logic        fire_i,  // Pulse request, one cycle
  input  wire logic [63:0] pat_i,   // Sources to pulse, 16 per bank
  output logic      [63:0] evt_o    // Event lines, idle low
);
  // Pulse lasts exactly as long as the request, so no event ever stretches
  assign evt_o = fire_i ? pat_i : 64'h0;
endmodule
`default_nettype wire

// [tb/flag_bank_checker.sv]
// Concurrent checks on the flag bank's top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_params.svh"
module flag_bank_checker
  import flag_bank_pkg::*;
(
  input wire logic                      mclk_i,         // Core clock
  input wire logic                      nrst_i,         // Async reset, low
  input wire flag_bank_pkg::reg_addr_t  addr_i,         // Index
  input wire flag_bank_pkg::flag_word_t wdata_i,        // Write data
  input wire logic                      wr_i,           // Write strobe
  input wire logic                      rd_i,           // Read strobe
  input wire flag_bank_pkg::flag_word_t rdata_o,        // Read data
  input wire logic                      timer7_evt_i,   // Fourth bank b0
  input wire logic                      uart2_tx_evt_i, // Second bank b15
  input wire flag_bank_pkg::flag_word_t flags_first_o,  // Flag words
  input wire flag_bank_pkg::flag_word_t flags_second_o,
  input wire flag_bank_pkg::flag_word_t flags_third_o,
  input wire flag_bank_pkg::flag_word_t flags_fourth_o,
  input wire logic                      irq_o           // Level request
);
  import flag_bank_pkg::*;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // No flag pending in any bank, so no request can follow
  sequence s_idle;
    (flags_first_o | flags_second_o | flags_third_o | flags_fourth_o) == 0;
  endsequence
  // Read strobe aimed at the fourth flag word
  sequence s_read4;
    rd_i && addr_i == `REG_FLAGS_FOURTH;
  endsequence
  a_idle_no_irq: assert property (s_idle |=> !irq_o)
    else $error("request without pending flag");
  a_read_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_read_flags: assert property (
      s_read4 |=> rdata_o == $past(flags_fourth_o))
    else $error("read data differs from flag word");
  a_unmapped_zero: assert property (
      rd_i && addr_i >= 4'h8 |=> !rdata_o)
    else $error("unmapped read not zero");
  a_unimpl_zero: assert property (((flags_first_o & ~`MASK_FIRST)
      | (flags_second_o & ~`MASK_SECOND) | (flags_third_o & ~`MASK_THIRD)
      | (flags_fourth_o & ~`MASK_FOURTH)) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_event_sets: assert property (
      timer7_evt_i |=> flags_fourth_o[0])
    else $error("timer7 event not latched");
  a_uart_sets: assert property (
      uart2_tx_evt_i |=> flags_second_o[15])
    else $error("uart2 tx event not latched");
  a_flag_holds: assert property (flags_fourth_o[0] &&
      !(wr_i && addr_i == `REG_FLAGS_FOURTH) |=> flags_fourth_o[0])
    else $error("flag dropped without write");
  a_write_clear: assert property (
      wr_i && addr_i == `REG_FLAGS_FOURTH &&
      !wdata_i[0] && !timer7_evt_i |=> !flags_fourth_o[0])
    else $error("write zero did not clear flag");
  a_write_load: assert property (
      wr_i && addr_i == `REG_FLAGS_SECOND &&
      !uart2_tx_evt_i |=> flags_second_o[15] == $past(wdata_i[15]))
    else $error("written flag value not held");
endmodule
bind interrupt_flag_status_bank flag_bank_checker flag_bank_checker_inst (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .timer7_evt_i(timer7_evt_i), .uart2_tx_evt_i(uart2_tx_evt_i),
  .flags_first_o(flags_first_o), .flags_second_o(flags_second_o),
  .flags_third_o(flags_third_o), .flags_fourth_o(flags_fourth_o));
`default_nettype wire

// [tb/tb_interrupt_flag_status_bank.sv]
// Self-checking bench of the interrupt flag bank
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_params.svh"
module tb_interrupt_flag_status_bank;
  import flag_bank_pkg::*;
  logic        mclk_i = 1'b0;    // 250 MHz clock
  logic        nrst_i = 1'b0;    // Reset, low
  reg_addr_t   addr   = 4'h0;    // Register index
  flag_word_t  wdata  = 16'h0000; // Write data
  logic        wr     = 1'b0;    // Write strobe
  logic        rd     = 1'b0;    // Read strobe
  logic        fire   = 1'b0;    // Event request
  logic [63:0] pat    = 64'h0;   // Event pattern, bank*16+bit
  logic [63:0] ev;               // Event lines
  flag_word_t  rdata;            // Read data
  flag_word_t  fl [4];           // Flag words
  logic        irq;              // Request line
  int          miscompares = 0;
  int          num_checks  = 0;
  // Implemented bits per bank, flags and enables alike
  localparam flag_word_t MSK [4] = '{`MASK_FIRST, `MASK_SECOND,
                                     `MASK_THIRD, `MASK_FOURTH};

  // Clock, 4 ns period
  initial forever #2 mclk_i = ~mclk_i;

  event_source event_source_inst (.fire_i(fire), .pat_i(pat), .evt_o(ev));

  // Unimplemented positions have no source, their lines stay unused
  interrupt_flag_status_bank interrupt_flag_status_bank_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .flags_first_o(fl[0]), .flags_second_o(fl[1]),
    .flags_third_o(fl[2]), .flags_fourth_o(fl[3]),
    .ocmp1_evt_i(ev[2]), .icap1_evt_i(ev[1]),
    .extpin0_evt_i(ev[0]),
    .uart2_tx_evt_i(ev[31]), .uart2_rx_evt_i(ev[30]), .extpin2_evt_i(ev[29]),
    .timer5_evt_i(ev[28]), .timer4_evt_i(ev[27]), .ocmp4_evt_i(ev[26]),
    .ocmp3_evt_i(ev[25]), .dma_ch2_done_evt_i(ev[24]),
    .icap8_evt_i(ev[23]), .icap7_evt_i(ev[22]), .adc2_done_evt_i(ev[21]),
    .extpin1_evt_i(ev[20]), .change_notify_evt_i(ev[19]),
    .i2c1_master_evt_i(ev[17]), .i2c1_slave_evt_i(ev[16]),
    .timer6_evt_i(ev[47]), .dma_ch4_done_evt_i(ev[46]), .ocmp8_evt_i(ev[44]),
    .ocmp7_evt_i(ev[43]), .ocmp6_evt_i(ev[42]), .ocmp5_evt_i(ev[41]),
    .icap6_evt_i(ev[40]),
    .icap5_evt_i(ev[39]), .icap4_evt_i(ev[38]),
    .icap3_evt_i(ev[37]), .dma_ch3_done_evt_i(ev[36]),
    .can1_event_evt_i(ev[35]), .can1_rx_ready_evt_i(ev[34]),
    .spi2_event_evt_i(ev[33]), .spi2_error_evt_i(ev[32]),
    .dma_ch5_done_evt_i(ev[61]), .codec_port_event_evt_i(ev[60]),
    .codec_port_error_evt_i(ev[59]), .can2_event_evt_i(ev[56]),
    .can2_rx_ready_evt_i(ev[55]), .extpin4_evt_i(ev[54]),
    .extpin3_evt_i(ev[53]), .timer9_evt_i(ev[52]), .timer8_evt_i(ev[51]),
    .i2c2_master_evt_i(ev[50]), .i2c2_slave_evt_i(ev[49]),
    .timer7_evt_i(ev[48]));

  // Counted comparison, reports at once on mismatch
  task automatic check(input flag_word_t got, input flag_word_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write; gap cycle keeps strobe edges apart
  task automatic wr_reg(input reg_addr_t a, input flag_word_t d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
    #1;
  endtask
  // One-cycle read, data judged in the following cycle only
  task automatic rd_reg(input reg_addr_t a, input flag_word_t exp);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // Single source pulse through the event model
  task automatic pulse(input int n);
    @(posedge mclk_i);
    pat  <= 64'h1 << n;
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    #1;
  endtask
  // Request line as a word for the shared compare
  function automatic flag_word_t irqw();
    return {15'h0000, irq};
  endfunction

  // All registers and an unmapped index read zero out of reset
  task automatic t_reset;
    for (int a = 0; a < 9; a++) rd_reg(4'(a), 16'h0000);
  endtask
  // Write ones then zeros everywhere; only implemented bits stick
  task automatic t_access;
    for (int a = 0; a < 9; a++) begin
      wr_reg(4'(a), 16'hffff);
      rd_reg(4'(a), (a < 8) ? MSK[a % 4] : 16'h0000);
      wr_reg(4'(a), 16'h0000);
      rd_reg(4'(a), 16'h0000);
    end
  endtask
  // Walk every bank position; each source lands on its own bit only
  task automatic t_map;
    flag_word_t e;
    flag_word_t x;
    for (int n = 0; n < 64; n++) begin
      pulse(n);
      e = (16'h0001 << (n % 16)) & MSK[n / 16];
      for (int b = 0; b < 4; b++) begin
        x = (b == n / 16) ? e : 16'h0000;
        check(fl[b], x);
      end
      rd_reg(4'(n / 16), e);
      wr_reg(4'(n / 16), 16'h0000);
    end
  endtask
  // Event beside a clearing write keeps its flag, the other bit clears
  task automatic t_race;
    pulse(48);
    pulse(55);
    @(posedge mclk_i);
    pat   <= 64'h1 << 48;
    fire  <= 1'b1;
    addr  <= `REG_FLAGS_FOURTH;
    wdata <= 16'h0000;
    wr    <= 1'b1;
    @(posedge mclk_i);
    fire  <= 1'b0;
    wr    <= 1'b0;
    #1;
    check(fl[3], 16'h0001);
    wr_reg(`REG_FLAGS_FOURTH, 16'h0000);
  endtask
  // Request follows enabled flags, masking and the handler's clear
  task automatic t_irq;
    wr_reg(`REG_ENABLE_FOURTH, 16'h0001);
    pulse(48);
    check(irqw(), 16'h0000);
    @(posedge mclk_i);
    #1;
    check(irqw(), 16'h0001);
    rd_reg(`REG_FLAGS_FOURTH, 16'h0001);
    pulse(49);
    wr_reg(`REG_ENABLE_FOURTH, 16'h0000);
    @(posedge mclk_i);
    #1;
    check(irqw(), 16'h0000);
    wr_reg(`REG_ENABLE_FOURTH, 16'h0002);
    @(posedge mclk_i);
    #1;
    check(irqw(), 16'h0001);
    wr_reg(`REG_FLAGS_FOURTH, 16'h0000);
    @(posedge mclk_i);
    #1;
    check(irqw(), 16'h0000);
  endtask
  // Reset in mid-run wipes flags and enables
  task automatic t_rst;
    wr_reg(`REG_ENABLE_SECOND, 16'hffff);
    pulse(31);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1;
    check(fl[1], 16'h0000);
    rd_reg(`REG_ENABLE_SECOND, 16'h0000);
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence after 4 cycles of reset
  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_access();
    t_map();
    t_race();
    t_irq();
    t_rst();
    finish_test();
  end
  // Watchdog, several times the expected run of about 510 cycles
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
